// ---- design/tscsp_pkg.sv ----
// Constants and types for the temperature conversion sequencer and serial port
// Behaviour
// - Sample input on rising clock while selected
// - Output next result bit on falling clock
// - Select high makes serial clock ignored
// - Start conversion every 400 us internally
// - Conversion lasts 25 us, then idles
// - Shift register holds latest completed result
// - Shutdown stops oscillator and further conversions
// - Shutdown keeps last result readable
// - Access end restarts oscillator, converts again
// - Leaving shutdown restarts oscillator and conversion
// - Early read repeats previous read value
// - Result is read-only 10-bit two's complement
// - Encoding spans minus 128 to 127 degrees
// - One step equals a quarter degree
// - 16 clocks, MSB first, hold, then float
// - Third written bit is power-down bit
// - Control loads on fifteenth falling edge only
package tscsp_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_KHZ = 20000;
   localparam int PERIOD_US = 400;
   localparam int CONV_US = 25;
   localparam int PERIOD_CYC_DEF = PERIOD_US * CLK_KHZ / 1000;
   localparam logic [9:0] CONV_CYC = 10'(CONV_US * CLK_KHZ / 1000);

   // ----------------------------------------
   // Serial word layout
   // ----------------------------------------
   localparam int RESULT_W = 10;
   localparam logic [4:0] WORD_LAST_FALL = 5'h0F;
   localparam logic [4:0] CTRL_LOAD_FALL = 5'h0E;
   localparam logic [4:0] PD_BIT_RISE = 5'h02;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   localparam logic [5:0] WORD_PAD = 6'h00;

   // ----------------------------------------
   // Reset values and buffer depth
   // ----------------------------------------
   localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;
   localparam logic PD_RST = 1'b0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef enum logic [1:0] {
      TSCSP_IDLE = 2'b00,
      TSCSP_CONV = 2'b01,
      TSCSP_PUSH = 2'b11
   } tscsp_conv_e;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } tscsp_pins_s;

   typedef struct packed {
      logic [1:0] cs_sy;
      logic [1:0] sclk_sy;
      logic [1:0] din_sy;
      logic sclk_prev;
      logic sel_prev;
      logic [15:0] tx;
      logic dout;
      logic [4:0] rcnt;
      logic [4:0] fcnt;
      logic pend;
      logic pd;
      tscsp_conv_e st;
      logic [12:0] pcnt;
      logic [9:0] ccnt;
      logic [RESULT_W-1:0] sample;
      logic [1:0][RESULT_W-1:0] fifo;
      logic wp;
      logic rp;
      logic [1:0] fcount;
      logic [RESULT_W-1:0] result;
   } tscsp_state_s;

endpackage

// ---- design/tscsp_top.sv ----
// Conversion sequencer, result buffer and serial slave port
`timescale 1ns/1ps
module tscsp_top
   import tscsp_pkg::*;
#(
   parameter int PERIOD_CYC = PERIOD_CYC_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial pins from the master
   input wire tscsp_pins_s pins,
   // Serial data out, driven while selected
   output logic dout,
   output logic dout_oe,
   // Converter front end, same clock
   input wire logic [RESULT_W-1:0] adc_code,
   // Status
   output logic conv_active,
   output logic shutdown
);

   tscsp_state_s s;
   tscsp_state_s next_s;
   logic sel;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;

   // ----------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------
   // Only the second synchroniser stage is read here
   assign sel = ~s.cs_sy[1];
   assign rise = sel & s.sclk_sy[1] & ~s.sclk_prev;
   assign fall = sel & ~s.sclk_sy[1] & s.sclk_prev;
   assign cs_fall = sel & ~s.sel_prev;
   assign cs_rise = ~sel & s.sel_prev;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic restart;
      logic start;
      logic push;
      logic pop;
      restart = 1'b0;
      start = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      next_s = s;
      next_s.cs_sy = {s.cs_sy[0], pins.cs_n};
      next_s.sclk_sy = {s.sclk_sy[0], pins.sclk};
      next_s.din_sy = {s.din_sy[0], pins.din};
      next_s.sclk_prev = s.sclk_sy[1];
      next_s.sel_prev = sel;

      // Serial shifting
      if (cs_fall) begin
         next_s.tx = {s.result, WORD_PAD};
         next_s.dout = s.result[RESULT_W-1];
         next_s.rcnt = 5'h00;
         next_s.fcnt = 5'h00;
         next_s.pend = 1'b0;
      end else begin
         if (rise) begin
            if (s.rcnt != CNT_MAX) begin
               next_s.rcnt = s.rcnt + 5'h01;
            end
            if (s.rcnt == PD_BIT_RISE) begin
               next_s.pend = s.din_sy[1];
            end
         end
         if (fall) begin
            if (s.fcnt != CNT_MAX) begin
               next_s.fcnt = s.fcnt + 5'h01;
            end
            // Past the last bit the output simply holds
            if (s.fcnt < WORD_LAST_FALL) begin
               next_s.tx = {s.tx[14:0], 1'b0};
               next_s.dout = s.tx[14];
            end
            if (s.fcnt == CTRL_LOAD_FALL) begin
               next_s.pd = s.pend;
            end
         end
      end

      // Oscillator restart after access or wake
      restart = (cs_rise | (s.pd & ~next_s.pd)) & ~next_s.pd;

      // Conversion schedule
      if (next_s.pd) begin
         next_s.pcnt = s.pcnt;
      end else if (restart) begin
         next_s.pcnt = 13'h0000;
         start = 1'b1;
      end else if (s.pcnt >= 13'(PERIOD_CYC - 1)) begin
         next_s.pcnt = 13'h0000;
         start = 1'b1;
      end else begin
         next_s.pcnt = s.pcnt + 13'h0001;
      end

      // Converter sequence; a conversion under way finishes even into shutdown
      case (s.st)
         TSCSP_IDLE: begin
            next_s.st = TSCSP_IDLE;
         end
         TSCSP_CONV: begin
            if (s.ccnt == CONV_CYC - 10'h001) begin
               next_s.sample = adc_code;
               next_s.st = TSCSP_PUSH;
            end else begin
               next_s.ccnt = s.ccnt + 10'h001;
            end
         end
         TSCSP_PUSH: begin
            // Full buffer stalls the converter here
            if (s.fcount != BUF_DEPTH) begin
               push = 1'b1;
               next_s.st = TSCSP_IDLE;
            end
         end
         default: begin
            next_s.st = TSCSP_IDLE;
         end
      endcase
      if (start && s.st != TSCSP_PUSH) begin
         next_s.st = TSCSP_CONV;
         next_s.ccnt = 10'h000;
      end

      // Two-entry buffer; drained only while the port is idle
      pop = (s.fcount != 2'h0) & ~sel;
      if (push) begin
         next_s.fifo[s.wp] = s.sample;
         next_s.wp = ~s.wp;
      end
      if (pop) begin
         next_s.result = s.fifo[s.rp];
         next_s.rp = ~s.rp;
      end
      next_s.fcount = s.fcount + {1'b0, push} - {1'b0, pop};
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.cs_sy <= 2'h3;
         s.sclk_sy <= 2'h3;
         s.sclk_prev <= 1'b1;
         s.pd <= PD_RST;
         s.st <= TSCSP_IDLE;
         s.pcnt <= 13'(PERIOD_CYC - 1);
         s.result <= RESULT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.dout;
   assign dout_oe = sel;
   assign conv_active = (s.st == TSCSP_CONV);
   assign shutdown = s.pd;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_shift;
      (fall && !cs_fall && s.fcnt < WORD_LAST_FALL) |=> (dout == $past(s.tx[14]));
   endproperty
   a_shift: assert property (p_shift) else $error("dout did not advance on falling edge");

   property p_deselect;
      !sel |=> ($stable(s.rcnt) && $stable(s.fcnt) && $stable(s.pd));
   endproperty
   a_deselect: assert property (p_deselect) else $error("serial state moved while deselected");

   property p_period;
      // A shutdown write landing in the same cycle legally suppresses the start
      (!s.pd && !next_s.pd && !cs_rise && s.pcnt == 13'(PERIOD_CYC - 1) && s.st == TSCSP_IDLE) |=>
         (s.st == TSCSP_CONV);
   endproperty
   a_period: assert property (p_period) else $error("periodic conversion not started");

   property p_conv_len;
      // A wake restart may land on the last count and restart the conversion
      (s.st == TSCSP_CONV && s.ccnt == CONV_CYC - 10'h001 && !cs_rise && !(s.pd && !next_s.pd)) |=>
         (s.st == TSCSP_PUSH);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_no_start_pd;
      // Leaving shutdown in this cycle starts a conversion on purpose
      (s.pd && next_s.pd && s.st == TSCSP_IDLE) |=> (s.st == TSCSP_IDLE);
   endproperty
   a_no_start_pd: assert property (p_no_start_pd) else $error("conversion started in shutdown");

   property p_hold_sel;
      sel |=> $stable(s.result);
   endproperty
   a_hold_sel: assert property (p_hold_sel) else $error("result changed during access");

   property p_restart;
      (cs_rise && !s.pd && s.st != TSCSP_PUSH) |=> (s.st == TSCSP_CONV && s.ccnt == 10'h000 && s.pcnt == 13'h0000);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after access");

   property p_ctrl;
      (fall && !cs_fall && s.fcnt == CTRL_LOAD_FALL) |=> (s.pd == $past(s.pend));
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control not loaded on fifteenth fall");

   property p_oe;
      s.cs_sy[1] |-> !dout_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("dout driven while deselected");

   property p_hold_out;
      (sel && !cs_fall && (!fall || s.fcnt >= WORD_LAST_FALL)) |=> $stable(dout);
   endproperty
   a_hold_out: assert property (p_hold_out) else $error("dout moved without a shifting fall");

endmodule

// ---- tb/tscsp_master.sv ----
// Serial master model for the temperature sequencer port
`timescale 1ns/1ps
module tscsp_master
   import tscsp_pkg::*;
(
   // Clock
   input wire logic clk,
   // Device pins
   input wire logic dout,
   input wire logic dout_oe,
   output tscsp_pins_s pins
);
   logic last = 1'b0;
   logic sdo;
   // Released line shows the inverse, never a stale bit
   assign sdo = dout_oe ? dout : ~last;
   always @(posedge clk) if (dout_oe) last <= dout;
   initial pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
   // ----------------------------------------
   // Frames
   // ----------------------------------------
   // Fewer than 15 pulses aborts before the control load
   task xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      @(posedge clk) #1 pins.cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         pins.din = w[15-i];
         repeat (4) @(posedge clk);
         #1 pins.sclk = 1'b1;
         r = {r[14:0], sdo};
         repeat (4) @(posedge clk);
         #1 pins.sclk = 1'b0;
      end
      repeat (4) @(posedge clk);
      #1 pins.cs_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Clock wiggles with data held high while deselected
   task idle_clk();
      repeat (32) begin
         repeat (4) @(posedge clk);
         #1 pins.sclk = ~pins.sclk;
         pins.din = 1'b1;
      end
   endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the temperature sequencer and serial port
`timescale 1ns/1ps
module tb_top
   import tscsp_pkg::*;
;
   localparam int PC = 1000;
   logic clk = 1'b0;
   logic rst_n;
   logic [9:0] adc_code;
   logic dout, dout_oe, conv_active, shutdown;
   tscsp_pins_s pins;
   int err_count = 0;
   int check_count = 0;
   int n, c;
   logic [15:0] r;
   logic [9:0] codes [4] = '{10'h200, 10'h3FF, 10'h001, 10'h1FC};
   always #25 clk = ~clk;
   tscsp_top #(.PERIOD_CYC(PC)) dut (.clk(clk), .rst_n(rst_n), .pins(pins), .dout(dout), .dout_oe(dout_oe),
      .adc_code(adc_code), .conv_active(conv_active), .shutdown(shutdown));
   tscsp_master mst (.clk(clk), .dout(dout), .dout_oe(dout_oe), .pins(pins));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task final_report();
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wait_lvl(input logic lvl, output int k);
      k = 0;
      while (conv_active !== lvl) begin
         tick(1);
         k++;
         if (k > 3 * PC) begin
            err_count++;
            final_report();
         end
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      adc_code = 10'h0C8;
      tick(12);
      rst_n = 1'b1;
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, c);
      chk1(c >= CONV_CYC - 1 && c <= CONV_CYC + 1, 1'b1);
      wait_lvl(1'b1, n);
      chk1(c + n >= PC - 1 && c + n <= PC + 1, 1'b1);
      wait_lvl(1'b0, c);
      tick(8);
      mst.xfer(16'h0000, 16, r);
      chk16(r, {10'h0C8, WORD_PAD});
      chk1(dout_oe, 1'b0);
      foreach (codes[k]) begin
         adc_code = codes[k];
         wait_lvl(1'b1, n);
         wait_lvl(1'b0, c);
         tick(8);
         mst.xfer(16'h0000, 16, r);
         chk16(r, {codes[k], WORD_PAD});
      end
      // Restarted conversion still running: old value again
      adc_code = 10'h155;
      mst.xfer(16'h0000, 16, r);
      chk16(r, {codes[3], WORD_PAD});
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, c);
      tick(8);
      mst.xfer(16'h0000, 16, r);
      chk16(r, {10'h155, WORD_PAD});
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, c);
      mst.xfer(16'h2000, 16, r);
      chk1(shutdown, 1'b1);
      adc_code = 10'h0AA;
      n = 0;
      repeat (3 * PC) begin
         tick(1);
         if (conv_active !== 1'b0) n++;
      end
      chk1(n == 0, 1'b1);
      mst.xfer(16'h2000, 16, r);
      chk16(r, {10'h155, WORD_PAD});
      mst.xfer(16'h0000, 14, r);
      chk1(shutdown, 1'b1);
      mst.xfer(16'h0000, 16, r);
      chk1(shutdown, 1'b0);
      wait_lvl(1'b1, n);
      chk1(n <= 4, 1'b1);
      wait_lvl(1'b0, c);
      tick(8);
      wait_lvl(1'b1, n);
      chk1(c + n + 8 >= PC - 4 && c + n + 8 <= PC + 1, 1'b1);
      mst.xfer(16'h0000, 16, r);
      chk16(r, {10'h0AA, WORD_PAD});
      // Cut frame leaves the load pending one fall away; stray clocks while deselected must not shut down
      mst.xfer(16'h2000, 14, r);
      chk1(shutdown, 1'b0);
      mst.idle_clk();
      chk1(shutdown, 1'b0);
      chk1(dout_oe, 1'b0);
      final_report();
   end
endmodule
